/* dwc_defines.vh */
// constants for the downstream window and capability register slice
// Functional notes
// RQ1: translated base bits 31:6 read-write, reset zero
// RQ2: setup register limits which base bits apply
// RQ3: setup bit 0 read-only zero, memory space
// RQ4: setup bits 2:1 address width, reset 00
// RQ5: setup bits 30:6 size mask, write gating
// RQ6: software keeps mask bits 11:6 zero
// RQ7: setup bit 31 enables window, reset off
// RQ8: capability id 10h, version 1h
// RQ9: next capability pointer reads D8h
// RQ10: port type 7h forward, 8h reverse
// RQ11: slot implemented 0 forward, 1 reverse
// RQ12: translation substitutes base where mask set
// RQ13: read-only writes ignored, reserved read zero
`ifndef DWC_DEFINES_VH
`define DWC_DEFINES_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define DWC_OFS_XBASE 8'ha8
`define DWC_OFS_SETUP 8'hac
`define DWC_OFS_CAPHDR 8'hb0
// ----------------------------------------
// field positions and fixed values
// ----------------------------------------
`define DWC_SETUP_EN_BIT 31
`define DWC_SETUP_PREF_BIT 3
`define DWC_MASK_LSB 6
`define DWC_XBASE_RST 26'h0000000
`define DWC_SETUP_RST 32'h00000000
`define DWC_CAP_ID 8'h10
`define DWC_CAP_NEXT 8'hd8
`define DWC_CAP_VER 4'h1
`define DWC_PT_FWD 4'h7
`define DWC_PT_REV 4'h8
`define DWC_ADDR_32 2'h0
`define DWC_ADDR_64 2'h1
`endif

/* dwc_init.sv */
// downstream initiator model, new address each cycle
`timescale 1ns/1ns
module dwc_init (
  input wire clk_i,
  input wire rstn_i,
  output reg [31:0] addr_o
);
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) addr_o <= 32'h0;
    else addr_o <= {addr_o[30:0], ~(addr_o[31] ^ addr_o[21])} ^ 32'h9e37;
  end
endmodule

/* dwc_regs.v */
// register slice: downstream window one and express capability header
`timescale 1ns/1ns
`include "dwc_defines.vh"
module dwc_regs (
  input wire CLK_I,
  input wire RESETN_I,
  input wire [7:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  input wire REVERSE_MODE_I,
  input wire WIDE_ADDR_I,
  input wire PREFETCH_I,
  input wire [24:0] SIZE_MASK_I,
  input wire WIN_EN_I,
  input wire SETUP_LOAD_I,
  input wire [31:0] DS_ADDR_I,
  output reg [31:0] DS_ADDR_O,
  output reg DS_HIT_EN_O
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [25:0] xbase_r;
  reg [1:0] awidth_r;
  reg pref_r;
  reg [24:0] mask_r;
  reg en_r;
  reg rev_s1_r;
  reg rev_r;
  reg busy_r;
  reg [31:0] rdata_nxt;
  wire [31:0] xaddr;
  wire [31:0] wmask;
  wire [31:0] setup_val;
  wire [31:0] cap_val;
  function [31:0] be_mask;
    input [3:0] be;
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
  assign wmask = be_mask(AVS_BYTEENABLE_I);
  // ----------------------------------------
  // mode strap synchroniser
  // ----------------------------------------
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rev_s1_r <= 1'b0;
      rev_r <= 1'b0;
    end else begin
      rev_s1_r <= REVERSE_MODE_I;
      rev_r <= rev_s1_r;
    end
  end
  // ----------------------------------------
  // register views
  // ----------------------------------------
  // RQ3 RQ4 RQ13
  assign setup_val = {en_r, mask_r, 2'b00, pref_r, awidth_r, 1'b0};
  assign cap_val = {2'b00, 5'h00, rev_r, // RQ11
    rev_r ? `DWC_PT_REV : `DWC_PT_FWD, // RQ10
    `DWC_CAP_VER, `DWC_CAP_NEXT, `DWC_CAP_ID}; // RQ8 RQ9
  // ----------------------------------------
  // setup loaded from the side strap port
  // ----------------------------------------
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      awidth_r <= `DWC_ADDR_32; // RQ4
      pref_r <= 1'b0;
      mask_r <= 25'h0000000; // RQ5
      en_r <= 1'b0; // RQ7
    end else if (SETUP_LOAD_I) begin
      awidth_r <= WIDE_ADDR_I ? `DWC_ADDR_64 : `DWC_ADDR_32; // RQ4
      pref_r <= PREFETCH_I;
      mask_r <= SIZE_MASK_I; // RQ5 RQ6
      en_r <= WIN_EN_I; // RQ7
    end
  end
  // ----------------------------------------
  // avalon slave: one wait cycle per access
  // ----------------------------------------
  always @* begin
    rdata_nxt = 32'h00000000;
    case (AVS_ADDRESS_I)
      `DWC_OFS_XBASE: begin
        rdata_nxt = {xbase_r, 6'h00}; // RQ13
      end
      `DWC_OFS_SETUP: begin
        rdata_nxt = setup_val;
      end
      `DWC_OFS_CAPHDR: begin
        rdata_nxt = cap_val;
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      busy_r <= 1'b0;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h00000000;
      xbase_r <= `DWC_XBASE_RST; // RQ1
    end else begin
      if ((AVS_READ_I || AVS_WRITE_I) && !busy_r) begin
        busy_r <= 1'b1;
        AVS_WAITREQUEST_O <= 1'b0;
        AVS_READDATA_O <= rdata_nxt;
      end else begin
        busy_r <= 1'b0;
        AVS_WAITREQUEST_O <= 1'b1;
      end
      if (AVS_WRITE_I && busy_r && (AVS_ADDRESS_I == `DWC_OFS_XBASE)) begin
        // only bit 31 and the mask-enabled bits take the write
        xbase_r <= (xbase_r & ~(wmask[31:6] & {1'b1, mask_r})) |
          (AVS_WRITEDATA_I[31:6] & wmask[31:6] & {1'b1, mask_r}); // RQ1 RQ5
      end
    end
  end
  // ----------------------------------------
  // translation output
  // ----------------------------------------
  dwc_xlate #(
    .AW(32)
  ) u_xlate (
    .addr_i(DS_ADDR_I),
    .base_i(xbase_r),
    .mask_i(mask_r),
    .en_i(en_r),
    .addr_o(xaddr)
  );
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      DS_ADDR_O <= 32'h00000000;
      DS_HIT_EN_O <= 1'b0;
    end else begin
      DS_ADDR_O <= xaddr; // RQ12
      DS_HIT_EN_O <= en_r; // RQ7
    end
  end
endmodule

/* dwc_regs_asserts.sv */
// assertions on the register slice ports
`timescale 1ns/1ns
module dwc_regs_asserts (
  input wire CLK_I, RESETN_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O,
  input wire REVERSE_MODE_I, WIN_EN_I, SETUP_LOAD_I, DS_HIT_EN_O,
  input wire [7:0] AVS_ADDRESS_I,
  input wire [31:0] AVS_READDATA_O, DS_ADDR_I, DS_ADDR_O
);
  wire rd = AVS_READ_I && !AVS_WAITREQUEST_O;
  wire [31:0] q = AVS_READDATA_O;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  AST_ANS: assert property ((AVS_READ_I || AVS_WRITE_I) &&
    AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("no answer");
  AST_ONE: assert property (!AVS_WAITREQUEST_O |=>
    AVS_WAITREQUEST_O) else $error("wait low too long");
  AST_CAP: assert property (rd && AVS_ADDRESS_I == 8'hb0 |->
    q[19:0] == 20'h1d810 && q[31:25] == 7'h0) else $error("cap hdr");
  AST_PT: assert property (rd && AVS_ADDRESS_I == 8'hb0 |->
    q[24:20] == (REVERSE_MODE_I ? 5'h18 : 5'h07)) else $error("port type");
  AST_SET: assert property (rd && AVS_ADDRESS_I == 8'hac |->
    q[5:4] == 2'h0 && !q[0] && !q[2]) else $error("setup ro bits");
  AST_XB: assert property (rd && AVS_ADDRESS_I == 8'ha8 |->
    q[5:0] == 6'h0) else $error("base low bits");
  AST_HIT: assert property (SETUP_LOAD_I ##1 !SETUP_LOAD_I[*2] |->
    DS_HIT_EN_O == $past(WIN_EN_I, 2)) else $error("hit enable");
  AST_PASS: assert property (!DS_HIT_EN_O && $past(!DS_HIT_EN_O) |->
    DS_ADDR_O == $past(DS_ADDR_I)) else $error("pass through");
  cover property (rd && AVS_ADDRESS_I == 8'hb0 && REVERSE_MODE_I);
  cover property (SETUP_LOAD_I && WIN_EN_I);
  cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
endmodule
bind dwc_regs dwc_regs_asserts i_chk (.*);

/* dwc_regs_tb.sv */
// self-checking bench for the register slice
`timescale 1ns/1ns
module dwc_regs_tb;
  reg CLK_I = 0, RESETN_I = 0, AVS_READ_I = 0, AVS_WRITE_I = 0;
  reg REVERSE_MODE_I = 0, WIDE_ADDR_I = 0, PREFETCH_I = 0, WIN_EN_I = 0;
  reg SETUP_LOAD_I = 0;
  reg [7:0] AVS_ADDRESS_I = 8'h0;
  reg [3:0] AVS_BYTEENABLE_I = 4'hf;
  reg [24:0] SIZE_MASK_I = 25'h0;
  reg [31:0] AVS_WRITEDATA_I = 32'h0, s = 32'd89302, d, a, m, r;
  wire [31:0] AVS_READDATA_O, DS_ADDR_I, DS_ADDR_O;
  wire AVS_WAITREQUEST_O, DS_HIT_EN_O;
  integer miscompares = 0, compares = 0, cyc = 0, i, n;
  dwc_regs i_dut (.*);
  dwc_init i_init (.clk_i(CLK_I), .rstn_i(RESETN_I), .addr_o(DS_ADDR_I));
  initial forever #50 CLK_I = ~CLK_I;
  function [31:0] rnd(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      rnd = y ^ (y << 5);
    end
  endfunction
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task bus(input w, input [7:0] ad, input [31:0] wd);
    begin
      AVS_READ_I <= !w;
      AVS_WRITE_I <= w;
      AVS_ADDRESS_I <= ad;
      AVS_WRITEDATA_I <= wd;
      n = 0;
      @(posedge CLK_I);
      while (AVS_WAITREQUEST_O !== 1'b0 && n < 50) begin
        @(posedge CLK_I);
        n = n + 1;
      end
      if (n == 50) miscompares = miscompares + 1;
      r = AVS_READDATA_O;
      AVS_READ_I <= 0;
      AVS_WRITE_I <= 0;
      @(posedge CLK_I);
    end
  endtask
  task wrap_up;
    begin
      $display("counts: %0d compares, %0d miscompares", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  always @(posedge CLK_I) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (12) @(posedge CLK_I);
    RESETN_I <= 1;
    repeat (3) @(posedge CLK_I);
    bus(0, 8'ha8, 0);
    chk("xbase", r, 0);
    bus(0, 8'hac, 0);
    chk("setup", r, 0);
    bus(0, 8'h40, 0);
    chk("unmapped", r, 0);
    for (i = 0; i < 2; i = i + 1) begin
      REVERSE_MODE_I <= i;
      bus(1, 8'hb0, rnd(s));
      repeat (2) @(posedge CLK_I);
      bus(0, 8'hb0, 0);
      chk("caphdr", r, i ? 32'h0181d810 : 32'h0071d810);
    end
    $display("test reset and header done");
    for (i = 0; i < 6; i = i + 1) begin
      s = rnd(s);
      SIZE_MASK_I <= {(i == 0) ? 19'h7ffff : s[24:6], 6'h0};
      WIN_EN_I <= s[31];
      WIDE_ADDR_I <= s[30];
      PREFETCH_I <= s[29];
      SETUP_LOAD_I <= 1;
      @(posedge CLK_I);
      SETUP_LOAD_I <= 0;
      m = {1'b1, (i == 0) ? 19'h7ffff : s[24:6], 12'h0};
      bus(1, 8'hac, 32'hffffffff);
      bus(0, 8'hac, 0);
      chk("setup", r, {s[31], m[30:6], 2'h0, s[29], 1'b0, s[30], 1'b0});
      d = rnd(s);
      bus(1, 8'ha8, d);
      bus(0, 8'ha8, 0);
      chk("xbase", r & (m | 32'h3f), d & m);
      chk("hit", DS_HIT_EN_O, s[31]);
      @(negedge CLK_I);
      a = DS_ADDR_I;
      @(negedge CLK_I);
      chk("xlate", DS_ADDR_O, s[31] ? (a & ~m) | (d & m) : a);
    end
    @(posedge CLK_I);
    d = r;
    AVS_BYTEENABLE_I <= 4'h8;
    bus(1, 8'ha8, 32'h0);
    AVS_BYTEENABLE_I <= 4'hf;
    bus(0, 8'ha8, 0);
    chk("bytelane", r, d & ~(m & 32'hff000000));
    $display("test window done");
    wrap_up;
  end
endmodule

/* dwc_xlate.v */
// downstream address translation for window one
`timescale 1ns/1ns
module dwc_xlate #(
  parameter AW = 32
) (
  input wire [AW-1:0] addr_i,
  input wire [25:0] base_i,
  input wire [24:0] mask_i,
  input wire en_i,
  output wire [AW-1:0] addr_o
);
  wire [31:0] full_mask;
  wire [31:0] full_base;
  // mask bit 31 always set so every enabled window swaps the top bit, whatever its size
  assign full_mask = {1'b1, mask_i, 6'h00};
  assign full_base = {base_i, 6'h00};
  // ----------------------------------------
  // substitute base bits under the size mask
  // ----------------------------------------
  assign addr_o = en_i ?
    ((addr_i & ~full_mask[AW-1:0]) | (full_base[AW-1:0] & full_mask[AW-1:0]))
    : addr_i; // RQ12 RQ2
endmodule
